// ==== design/mcs_pkg.sv ====
package mcs_pkg;

   // ------------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  OFF_CFG3   = 8'h00;
   localparam logic [7:0]  OFF_CFG4   = 8'h04;
   localparam logic [7:0]  OFF_CFG5   = 8'h08;
   localparam logic [7:0]  OFF_CFG6   = 8'h0c;
   localparam logic [7:0]  OFF_USER   = 8'h10;
   localparam logic [7:0]  OFF_STAT   = 8'h14;
   localparam logic [7:0]  OFF_POT    = 8'h18;
   localparam logic [7:0]  OFF_ISTAT  = 8'h1c;
   localparam logic [7:0]  OFF_IMASK  = 8'h20;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int CFG3_GPO_VAL_BIT   = 0;
   localparam int CFG3_PIN_FN_BIT    = 2;
   localparam int CFG3_GPO_SEL_BIT   = 4;
   localparam int CFG4_LASER_SHUTDOWN_OUT_MASK_BIT = 7;
   localparam int CFG5_FLT_POL_BIT   = 4;
   localparam int CFG6_TRS_SEL_BIT   = 2;
   localparam int CFG6_LOS_POL_BIT   = 3;
   localparam int USER_SOFT_OFF_BIT  = 0;
   localparam int USER_SOFT_TXR_BIT  = 1;
   localparam int USER_SOFT_RXR_BIT  = 2;
   localparam int USER_IRQ_EN_BIT    = 4;
   localparam int ST_TX_FAULT_BIT    = 0;
   localparam int ST_TX_OFF_BIT      = 1;
   localparam int ST_TX_RATE_BIT     = 2;
   localparam int ST_RX_RATE_BIT     = 3;
   localparam int ST_EXT_FAULT_BIT   = 4;
   localparam int ST_LASER_SHUTDOWN_OUT_BIT        = 5;
   localparam int EV_FAULT_BIT       = 0;
   localparam int EV_OFF_BIT         = 1;
   localparam int EV_TXR_BIT         = 2;
   localparam int EV_RXR_BIT         = 3;
   localparam int EV_W               = 4;
   localparam int POT_W              = 5;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]       CFG_RST   = 8'h00;
   localparam logic [7:0]       USER_RST  = 8'h00;
   localparam logic [POT_W-1:0] POT_RST   = 5'h00;
   localparam logic [EV_W-1:0]  IMASK_RST = 4'h0;

endpackage

// ==== design/mcs_sync.sv ====
`timescale 1ns/10ps

// Two-stage synchroniser for a group of pin levels.
module mcs_sync
   import mcs_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } mcs_sync_state_type;

   mcs_sync_state_type state;
   mcs_sync_state_type next_state;

   always_comb
   begin
      next_state.stage1 = d_i;
      next_state.stage2 = state.stage1;
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         state <= '0;
      else
         state <= next_state;
   end

   assign q_o = state.stage2;

endmodule // mcs_sync

// ==== design/mcs_irq.sv ====
`timescale 1ns/10ps

// Sticky event flags, write-one-to-clear, masked onto one level.
module mcs_irq
   import mcs_pkg::*;
#(
   parameter int WIDTH = EV_W
)
(
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] event_i,
   input  wire logic [WIDTH-1:0] clear_i,
   input  wire logic [WIDTH-1:0] mask_i,
   output logic      [WIDTH-1:0] status_o,
   output logic                  irq_o
);

   typedef struct packed {
      logic [WIDTH-1:0] status;
   } mcs_irq_state_type;

   mcs_irq_state_type state;
   mcs_irq_state_type next_state;

   // A set arriving with its clear wins.
   always_comb
   begin
      next_state.status = (state.status & ~clear_i) | event_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         state <= '0;
      else
         state <= next_state;
   end

   assign status_o = state.status;
   assign irq_o    = |(state.status & mask_i);

endmodule // mcs_irq

// ==== design/mcs_pins.sv ====
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - Config-three bit 2 low drives shared pin as shutdown; high makes it input.
// - Shutdown asserts on fault unless config-four bit 7 masks it.
// - In input mode, external fault level ORs with internal faults into fault.
// - Fault output is open-drain; config-five bit 4 selects active-high or low.
// - Status always shows the actual transmit-fault pin level.
// - Transmitter is off when disable input high or soft disable bit set.
// - Status always shows the transmit-disable input level.
// - Transmit rate output is rate input ORed with soft transmit rate bit.
// - Status always shows the transmit rate-select input level.
// - Receive rate output is rate input ORed with soft receive rate bit.
// - Status always shows the receive rate-select input level.
// - Irq enable resets to 0 keeping analog input; 1 makes open-drain output.
// - As output, the supply-monitor pin carries the active-low interrupt.
// - A 5-bit register selects the receive-power potentiometer tap.
// - Transmit rate appears on loss pin only when config-six bit 2 set.
// - Receive rate on its pin only when config-three bit 4 clear, else GPO.
module mcs_pins
   import mcs_pkg::*;
(
   input  wire logic              CLK_I,
   input  wire logic              RESETN_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic              INT_FAULT_I,
   input  wire logic              LOSS_I,
   input  wire logic              LASER_SHUTDOWN_OUT_FLT_PIN_I,
   output logic                   LASER_SHUTDOWN_OUT_FLT_PIN_O,
   output logic                   LASER_SHUTDOWN_OUT_FLT_PIN_OE_O,
   input  wire logic              TX_FAULT_PIN_I,
   output logic                   TX_FAULT_PIN_O,
   output logic                   TX_FAULT_PIN_OE_O,
   input  wire logic              TX_OFF_I,
   output logic                   TX_DISABLE_O,
   input  wire logic              TX_RATE_SEL_I,
   input  wire logic              RX_RATE_SEL_I,
   output logic                   LOSS_PIN_O,
   output logic                   LOSS_PIN_OE_O,
   output logic                   RX_RATE_PIN_O,
   output logic                   RX_RATE_PIN_OE_O,
   output logic                   SUPPLY_IRQ_PIN_O,
   output logic                   SUPPLY_IRQ_PIN_OE_O,
   output logic                   SUPPLY_ANALOG_SEL_O,
   output logic                   IRQ_O,
   output logic      [POT_W-1:0]  RX_POT_TAP_O
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       cfg3;
      logic [7:0]       cfg4;
      logic [7:0]       cfg5;
      logic [7:0]       cfg6;
      logic [7:0]       user;
      logic [POT_W-1:0] pot;
      logic [EV_W-1:0]  imask;
      logic [31:0]      prdata;
      logic             prev_fault;
      logic             prev_off;
      logic             prev_txr;
      logic             prev_rxr;
      logic             laser_shutdown_out_o;
      logic             laser_shutdown_out_oe;
      logic             flt_oe;
      logic             tx_dis;
      logic             loss_oe;
      logic             rxr_o;
      logic             rxr_oe;
      logic             irq_oe;
   } mcs_pins_state_type;

   localparam mcs_pins_state_type RESET_STATE = '{
      cfg3: CFG_RST, cfg4: CFG_RST, cfg5: CFG_RST, cfg6: CFG_RST,
      user: USER_RST, pot: POT_RST, imask: IMASK_RST,
      default: '0};

   mcs_pins_state_type state;
   mcs_pins_state_type next_state;

   logic [4:0]      pins_sync;
   logic            ext_fault_s;
   logic            flt_pin_s;
   logic            off_s;
   logic            txr_s;
   logic            rxr_s;
   logic            fault_all;
   logic            tx_rate;
   logic            rx_rate;
   logic            irq_level;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] ev_clear;
   logic [EV_W-1:0] ev_status;
   logic [7:0]      status;
   logic            setup;
   logic            wr_acc;
   logic            hit;
   logic [31:0]     rd_mux;

   // -------------------------------------------------------------------
   // Pin input synchronisers
   // -------------------------------------------------------------------
   mcs_sync #(.WIDTH(5)) u_sync (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .d_i      ({LASER_SHUTDOWN_OUT_FLT_PIN_I, TX_FAULT_PIN_I, TX_OFF_I,
                  TX_RATE_SEL_I, RX_RATE_SEL_I}),
      .q_o      (pins_sync)
   );

   assign ext_fault_s = pins_sync[4];
   assign flt_pin_s   = pins_sync[3];
   assign off_s       = pins_sync[2];
   assign txr_s       = pins_sync[1];
   assign rxr_s       = pins_sync[0];

   // -------------------------------------------------------------------
   // Pin functions
   // -------------------------------------------------------------------
   assign fault_all = INT_FAULT_I
                    | (state.cfg3[CFG3_PIN_FN_BIT] & ext_fault_s);
   assign tx_rate   = txr_s | state.user[USER_SOFT_TXR_BIT];
   assign rx_rate   = rxr_s | state.user[USER_SOFT_RXR_BIT];

   assign status = {2'b00,
                    state.laser_shutdown_out_o,
                    ext_fault_s,
                    rxr_s,
                    txr_s,
                    off_s,
                    flt_pin_s
                   };

   assign events[EV_FAULT_BIT] = fault_all & ~state.prev_fault;
   assign events[EV_OFF_BIT]   = off_s ^ state.prev_off;
   assign events[EV_TXR_BIT]   = txr_s ^ state.prev_txr;
   assign events[EV_RXR_BIT]   = rxr_s ^ state.prev_rxr;

   // -------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------
   assign setup  = PSEL_I & ~PENABLE_I;
   assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I & hit;

   always_comb
   begin
      hit    = 1'b1;
      rd_mux = '0;
      case (PADDR_I)
         OFF_CFG3:  rd_mux[7:0] = state.cfg3;
         OFF_CFG4:  rd_mux[7:0] = state.cfg4;
         OFF_CFG5:  rd_mux[7:0] = state.cfg5;
         OFF_CFG6:  rd_mux[7:0] = state.cfg6;
         OFF_USER:  rd_mux[7:0] = state.user;
         OFF_STAT:  rd_mux[7:0] = status;
         OFF_POT:   rd_mux[POT_W-1:0] = state.pot;
         OFF_ISTAT: rd_mux[EV_W-1:0] = ev_status;
         OFF_IMASK: rd_mux[EV_W-1:0] = state.imask;
         default:   hit = 1'b0;
      endcase
   end

   assign ev_clear = (wr_acc && PADDR_I == OFF_ISTAT)
                     ? PWDATA_I[EV_W-1:0] : '0;

   mcs_irq #(.WIDTH(EV_W)) u_irq (
      .clk_i    (CLK_I),
      .resetn_i (RESETN_I),
      .event_i  (events),
      .clear_i  (ev_clear),
      .mask_i   (state.imask),
      .status_o (ev_status),
      .irq_o    (irq_level)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb
   begin
      next_state            = state;
      next_state.prev_fault = fault_all;
      next_state.prev_off   = off_s;
      next_state.prev_txr   = txr_s;
      next_state.prev_rxr   = rxr_s;

      // Read data is captured in the setup cycle and shown in access.
      if (setup)
         next_state.prdata = rd_mux;

      if (wr_acc)
      begin
         case (PADDR_I)
            OFF_CFG3:  next_state.cfg3  = PWDATA_I[7:0];
            OFF_CFG4:  next_state.cfg4  = PWDATA_I[7:0];
            OFF_CFG5:  next_state.cfg5  = PWDATA_I[7:0];
            OFF_CFG6:  next_state.cfg6  = PWDATA_I[7:0];
            OFF_USER:  next_state.user  = PWDATA_I[7:0];
            OFF_POT:   next_state.pot   = PWDATA_I[POT_W-1:0];
            OFF_IMASK: next_state.imask = PWDATA_I[EV_W-1:0];
            default:   next_state.imask = state.imask;
         endcase
      end

      // Shared pin: shutdown output or external fault input.
      next_state.laser_shutdown_out_oe = ~state.cfg3[CFG3_PIN_FN_BIT];
      next_state.laser_shutdown_out_o  = ~state.cfg3[CFG3_PIN_FN_BIT]
                         & INT_FAULT_I
                         & ~state.cfg4[CFG4_LASER_SHUTDOWN_OUT_MASK_BIT];

      // Open-drain fault pin pulls low when the wanted level is low.
      next_state.flt_oe = ~(fault_all
                          ^ state.cfg5[CFG5_FLT_POL_BIT]);

      next_state.tx_dis = off_s
                        | state.user[USER_SOFT_OFF_BIT];

      if (state.cfg6[CFG6_TRS_SEL_BIT])
         next_state.loss_oe = ~tx_rate;
      else
         next_state.loss_oe = ~(LOSS_I ^ state.cfg6[CFG6_LOS_POL_BIT]);

      if (state.cfg3[CFG3_GPO_SEL_BIT])
      begin
         // General-purpose output is push-pull.
         next_state.rxr_o  = state.cfg3[CFG3_GPO_VAL_BIT];
         next_state.rxr_oe = 1'b1;
      end
      else
      begin
         next_state.rxr_o  = 1'b0;
         next_state.rxr_oe = ~rx_rate;
      end

      next_state.irq_oe = state.user[USER_IRQ_EN_BIT]
                        & irq_level;
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RESETN_I)
         state <= RESET_STATE;
      else
         state <= next_state;
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign PRDATA_O            = state.prdata;
   assign PREADY_O            = 1'b1;
   assign PSLVERR_O           = PSEL_I & PENABLE_I & ~hit;
   assign LASER_SHUTDOWN_OUT_FLT_PIN_O      = state.laser_shutdown_out_o;
   assign LASER_SHUTDOWN_OUT_FLT_PIN_OE_O   = state.laser_shutdown_out_oe;
   assign TX_FAULT_PIN_O      = 1'b0;
   assign TX_FAULT_PIN_OE_O   = state.flt_oe;
   assign TX_DISABLE_O        = state.tx_dis;
   assign LOSS_PIN_O          = 1'b0;
   assign LOSS_PIN_OE_O       = state.loss_oe;
   assign RX_RATE_PIN_O       = state.rxr_o;
   assign RX_RATE_PIN_OE_O    = state.rxr_oe;
   assign SUPPLY_IRQ_PIN_O    = 1'b0;
   assign SUPPLY_IRQ_PIN_OE_O = state.irq_oe;
   assign SUPPLY_ANALOG_SEL_O = ~state.user[USER_IRQ_EN_BIT];
   assign IRQ_O               = irq_level;
   assign RX_POT_TAP_O        = state.pot;

endmodule // mcs_pins

// ==== tb/mcs_host_model.sv ====
`timescale 1ns/10ps

// Host cage side of the shared shutdown pin and the fault line.
module mcs_host_model
(
   input  wire logic ext_fault_i,
   input  wire logic laser_shutdown_out_o_i,
   input  wire logic laser_shutdown_out_oe_i,
   input  wire logic fault_oe_i,
   output logic      shared_pin_o,
   output logic      fault_pin_o
);
   // The cage drives its fault level only while the device lets go.
   assign shared_pin_o = laser_shutdown_out_oe_i ? laser_shutdown_out_o_i : ext_fault_i;
   // A pull-up holds the fault line high unless the device sinks it.
   assign fault_pin_o = fault_oe_i ? 1'b0 : 1'b1;
endmodule // mcs_host_model

// ==== tb/mcs_pins_sva.sv ====
`timescale 1ns/10ps

module mcs_pins_sva
   import mcs_pkg::*;
(
   input wire logic              CLK_I,
   input wire logic              RESETN_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic              PWRITE_I,
   input wire logic [ADDR_W-1:0] PADDR_I,
   input wire logic              INT_FAULT_I,
   input wire logic              TX_OFF_I,
   input wire logic              LASER_SHUTDOWN_OUT_FLT_PIN_O,
   input wire logic              LASER_SHUTDOWN_OUT_FLT_PIN_OE_O,
   input wire logic              TX_FAULT_PIN_O,
   input wire logic              TX_FAULT_PIN_OE_O,
   input wire logic              TX_DISABLE_O,
   input wire logic              SUPPLY_IRQ_PIN_O,
   input wire logic              SUPPLY_IRQ_PIN_OE_O,
   input wire logic              SUPPLY_ANALOG_SEL_O,
   input wire logic              IRQ_O,
   input wire logic [POT_W-1:0]  RX_POT_TAP_O
);
   logic [2:0] up;

   // Counts edges since reset so that synchroniser history is valid.
   always_ff @(posedge CLK_I)
   begin
      if (!RESETN_I)
         up <= 3'h0;
      else if (up != 3'h7)
         up <= up + 3'h1;
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   sequence off_held;
      TX_OFF_I ##1 TX_OFF_I ##1 TX_OFF_I;
   endsequence

   tx_off_follow_a: assert property ((up == 3'h7 ##0 off_held) |=> TX_DISABLE_O)
      else $error("transmitter left on while disable input held");
   shared_pin_init_a: assert property ($rose(RESETN_I) |-> ##[1:2] LASER_SHUTDOWN_OUT_FLT_PIN_OE_O)
      else $error("shared pin not driven as shutdown after reset");
   laser_shutdown_out_cause_a: assert property (up != 3'h0 && LASER_SHUTDOWN_OUT_FLT_PIN_O |-> $past(INT_FAULT_I))
      else $error("shutdown asserted without a fault");
   fault_od_a: assert property (TX_FAULT_PIN_OE_O |-> !TX_FAULT_PIN_O)
      else $error("fault pin driven high");
   irq_pin_od_a: assert property (SUPPLY_IRQ_PIN_OE_O |-> !SUPPLY_IRQ_PIN_O)
      else $error("interrupt pin driven high");
   irq_pin_cause_a: assert property (SUPPLY_IRQ_PIN_OE_O |-> $past(IRQ_O) && $past(!SUPPLY_ANALOG_SEL_O))
      else $error("interrupt pin pulled without enabled interrupt");
   irq_rest_a: assert property ($rose(RESETN_I) |-> !IRQ_O && SUPPLY_ANALOG_SEL_O)
      else $error("interrupt pin not analog after reset");
   pot_write_a: assert property (up != 3'h0 && $changed(RX_POT_TAP_O) |-> $past(PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == OFF_POT))
      else $error("tap changed without a write");
endmodule // mcs_pins_sva

bind mcs_pins mcs_pins_sva mcs_pins_sva_inst (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .INT_FAULT_I(INT_FAULT_I), .TX_OFF_I(TX_OFF_I),
   .LASER_SHUTDOWN_OUT_FLT_PIN_O(LASER_SHUTDOWN_OUT_FLT_PIN_O), .LASER_SHUTDOWN_OUT_FLT_PIN_OE_O(LASER_SHUTDOWN_OUT_FLT_PIN_OE_O),
   .TX_FAULT_PIN_O(TX_FAULT_PIN_O), .TX_FAULT_PIN_OE_O(TX_FAULT_PIN_OE_O),
   .TX_DISABLE_O(TX_DISABLE_O), .SUPPLY_IRQ_PIN_O(SUPPLY_IRQ_PIN_O),
   .SUPPLY_IRQ_PIN_OE_O(SUPPLY_IRQ_PIN_OE_O), .IRQ_O(IRQ_O),
   .SUPPLY_ANALOG_SEL_O(SUPPLY_ANALOG_SEL_O), .RX_POT_TAP_O(RX_POT_TAP_O));

// ==== tb/testbench.sv ====
`timescale 1ns/10ps

module testbench
   import mcs_pkg::*;
;
   logic clk, rstn, psel, pen, pwr, int_fault, loss, tx_off, txr, rxr, ext;
   logic pready, pslverr, err, laser_shutdown_out_o, laser_shutdown_out_oe, laser_shutdown_out_pin, flt_o, flt_oe;
   logic flt_pin, tx_dis, loss_oe, rxp_o, rxp_oe, sup_o, sup_oe, ana, irq;
   logic [31:0]      prdata, rdata, pwdata;
   logic [7:0]       paddr;
   logic [POT_W-1:0] pot;
   int               failures, comparisons;

   mcs_pins mcs_pins_inst (.CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .INT_FAULT_I(int_fault), .LOSS_I(loss), .LASER_SHUTDOWN_OUT_FLT_PIN_I(laser_shutdown_out_pin),
      .LASER_SHUTDOWN_OUT_FLT_PIN_O(laser_shutdown_out_o), .LASER_SHUTDOWN_OUT_FLT_PIN_OE_O(laser_shutdown_out_oe),
      .TX_FAULT_PIN_I(flt_pin), .TX_FAULT_PIN_O(flt_o),
      .TX_FAULT_PIN_OE_O(flt_oe), .TX_OFF_I(tx_off), .TX_DISABLE_O(tx_dis),
      .TX_RATE_SEL_I(txr), .RX_RATE_SEL_I(rxr), .LOSS_PIN_O(),
      .LOSS_PIN_OE_O(loss_oe), .RX_RATE_PIN_O(rxp_o), .RX_RATE_PIN_OE_O(rxp_oe),
      .SUPPLY_IRQ_PIN_O(sup_o), .SUPPLY_IRQ_PIN_OE_O(sup_oe),
      .SUPPLY_ANALOG_SEL_O(ana), .IRQ_O(irq), .RX_POT_TAP_O(pot));

   mcs_host_model mcs_host_model_inst (.ext_fault_i(ext), .laser_shutdown_out_o_i(laser_shutdown_out_o),
      .laser_shutdown_out_oe_i(laser_shutdown_out_oe), .fault_oe_i(flt_oe), .shared_pin_o(laser_shutdown_out_pin),
      .fault_pin_o(flt_pin));

   task end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task chb(input string nm, input logic seen, input logic exp);
      chk(nm, {31'h0, seen}, {31'h0, exp});
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         failures++;
         end_of_test;
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task settle;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task t_reset;
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0);
         if (i != 5)
            chk("reset value", rdata, 32'h0);
      end
      apb(1'b0, 8'h24, 32'h0);
      chb("unmapped error", err, 1'b1);
      chk("unmapped data", rdata, 32'h0);
      apb(1'b1, OFF_STAT, 32'hff);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("status idle", rdata, 32'h0);
      chb("shared pin drive", laser_shutdown_out_oe, 1'b1);
      chb("analog select", ana, 1'b1);
   endtask

   task t_fault;
      int_fault <= 1'b1;
      settle;
      chb("shutdown", laser_shutdown_out_o, 1'b1);
      chb("fault high", flt_oe, 1'b0);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("status fault", rdata, 32'h31);
      apb(1'b1, OFF_CFG4, 32'h80);
      settle;
      chb("shutdown masked", laser_shutdown_out_o, 1'b0);
      apb(1'b1, OFF_CFG3, 32'h04);
      int_fault <= 1'b0;
      ext <= 1'b1;
      settle;
      chb("shared pin input", laser_shutdown_out_oe, 1'b0);
      chb("external fault", flt_oe, 1'b0);
      apb(1'b1, OFF_CFG5, 32'h10);
      settle;
      chb("fault low", flt_oe, 1'b1);
      ext <= 1'b0;
      settle;
      chb("no fault low", flt_oe, 1'b0);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("status pin", rdata, 32'h01);
      apb(1'b1, OFF_CFG3, 32'h0);
      apb(1'b1, OFF_CFG4, 32'h0);
      apb(1'b1, OFF_CFG5, 32'h0);
   endtask

   task t_txoff;
      tx_off <= 1'b1;
      settle;
      chb("disable pin", tx_dis, 1'b1);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("status off", rdata, 32'h02);
      tx_off <= 1'b0;
      apb(1'b1, OFF_USER, 32'h01);
      settle;
      chb("soft disable", tx_dis, 1'b1);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("status on", rdata, 32'h00);
      apb(1'b1, OFF_USER, 32'h00);
      settle;
      chb("enabled", tx_dis, 1'b0);
   endtask

   task t_rate;
      logic [3:0] v;
      apb(1'b1, OFF_CFG6, 32'h04);
      for (int i = 0; i < 16; i++)
      begin
         v = 4'(i);
         apb(1'b1, OFF_USER, {29'h0, v[3], v[1], 1'b0});
         txr <= v[0];
         rxr <= v[2];
         settle;
         chb("tx rate pin", loss_oe, !(v[0] | v[1]));
         chb("rx rate pin", rxp_oe, !(v[2] | v[3]));
         apb(1'b0, OFF_STAT, 32'h0);
         chk("rate status", rdata, {28'h0, v[2], v[0], 2'h0});
      end
      apb(1'b1, OFF_CFG3, 32'h11);
      apb(1'b1, OFF_CFG6, 32'h00);
      settle;
      chb("gpo drive", rxp_oe, 1'b1);
      chb("gpo value", rxp_o, 1'b1);
      chb("loss pin", loss_oe, 1'b1);
      apb(1'b1, OFF_CFG6, 32'h08);
      settle;
      chb("loss pin inverted", loss_oe, 1'b0);
      loss <= 1'b1;
      settle;
      chb("loss pin active", loss_oe, 1'b1);
      loss <= 1'b0;
      apb(1'b1, OFF_CFG6, 32'h00);
      apb(1'b1, OFF_CFG3, 32'h00);
      apb(1'b1, OFF_USER, 32'h00);
   endtask

   task t_irq;
      apb(1'b1, OFF_IMASK, 32'h2);
      apb(1'b1, OFF_ISTAT, 32'hf);
      apb(1'b1, OFF_USER, 32'h10);
      settle;
      chb("irq idle", irq, 1'b0);
      chb("pin output", ana, 1'b0);
      tx_off <= 1'b1;
      settle;
      chb("irq raised", irq, 1'b1);
      chb("irq pin low", sup_oe, 1'b1);
      apb(1'b0, OFF_ISTAT, 32'h0);
      chk("event", rdata, 32'h2);
      apb(1'b1, OFF_IMASK, 32'h0);
      settle;
      chb("irq masked", irq, 1'b0);
      chb("irq pin free", sup_oe, 1'b0);
      apb(1'b1, OFF_IMASK, 32'h2);
      apb(1'b1, OFF_ISTAT, 32'h2);
      settle;
      chb("irq cleared", irq, 1'b0);
      apb(1'b1, OFF_USER, 32'h00);
      tx_off <= 1'b0;
      settle;
      chb("pin analog", ana, 1'b1);
   endtask

   task t_pot;
      apb(1'b1, OFF_POT, 32'h3f);
      apb(1'b0, OFF_POT, 32'h0);
      chk("tap read", rdata, 32'h1f);
      chk("tap pins", {27'h0, pot}, 32'h1f);
   endtask

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      {rstn, psel, pen, pwr, int_fault, loss, tx_off, txr, rxr, ext} = 10'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      failures = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_fault;
      t_txoff;
      t_rate;
      t_irq;
      t_pot;
      end_of_test;
   end
endmodule // testbench
